// *** core/ers_defs.svh ***
`ifndef ERS_DEFS_SVH
`define ERS_DEFS_SVH

// System register encodings {op0, op1, CRn, CRm, op2}.
`define ERS_ENC_COUNT_ID     16'hC298
`define ERS_ENC_SELECT       16'hC299
`define ERS_ENC_SR_FEATURE   16'hC2A0
`define ERS_ENC_SR_CONTROL   16'hC2A1
`define ERS_ENC_SR_STATUS    16'hC2A2
`define ERS_ENC_SR_ADDR      16'hC2A3
`define ERS_ENC_SR_PF_FEAT   16'hC2A4
`define ERS_ENC_SR_PF_CTRL   16'hC2A5
`define ERS_ENC_SR_PF_CDN    16'hC2A6
`define ERS_ENC_SR_MISC0     16'hC2A8
`define ERS_ENC_SR_MISC1     16'hC2A9
`define ERS_ENC_SR_MISC2     16'hC2AA
`define ERS_ENC_SR_MISC3     16'hC2AB

// Record count and field layout.
`define ERS_NUM_RECORDS      16'h0002
`define ERS_NUM_MSB          15
`define ERS_SEL_BIT          0
`define ERS_SELECT_RESET     1'h0
`define ERS_RECORD_RESET     64'h0000000000000000
`define ERS_TRAP_CLASS       6'h18

`endif

// *** core/ers_pkg.sv ***
package ers_pkg;

  typedef enum logic [1:0] {
    ERS_EL0,
    ERS_EL1,
    ERS_EL2,
    ERS_EL3
  } ers_el_t;

  typedef enum logic [1:0] {
    ERS_OK,
    ERS_UNDEF,
    ERS_TRAP_EL2,
    ERS_TRAP_EL3
  } ers_outcome_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] enc;
    ers_el_t     el;
    logic [63:0] wdata;
  } ers_req_t;

  typedef struct packed {
    logic el2_enabled;
    logic hyp_error_reg_trap;
    logic monitor_error_reg_trap;
    logic fine_trap_enable;
    logic fine_read_trap_count_id;
    logic fine_read_trap_select;
    logic fine_write_trap_select;
  } ers_trap_cfg_t;

  typedef struct packed {
    logic         valid;
    ers_outcome_t outcome;
    logic [5:0]   syndrome_class;
    logic [63:0]  rdata;
  } ers_resp_t;

  typedef struct packed {
    logic [63:0] control;
    logic [63:0] status;
    logic [63:0] pf_ctrl;
    logic [63:0] misc1;
    logic [63:0] misc2;
    logic [63:0] misc3;
  } ers_record_t;

endpackage

// *** core/ers_record_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "ers_defs.svh"

// One error record's resettable selected-record registers.
module ers_record_bank
  import ers_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Write port
  input  wire logic        i_wr,
  input  wire logic [15:0] i_enc,
  input  wire logic [63:0] i_wdata,
  // Read port
  input  wire logic [15:0] i_rd_enc,
  output logic             o_hit,
  output logic [63:0]      o_rdata
);

  ers_record_t state_reg;
  ers_record_t state_next;

  always_comb begin
    state_next = state_reg;
    if (i_wr) begin
      case (i_enc)
        `ERS_ENC_SR_CONTROL: state_next.control = i_wdata;
        `ERS_ENC_SR_STATUS:  state_next.status  = i_wdata;
        `ERS_ENC_SR_PF_CTRL: state_next.pf_ctrl = i_wdata;
        `ERS_ENC_SR_MISC1:   state_next.misc1   = i_wdata;
        `ERS_ENC_SR_MISC2:   state_next.misc2   = i_wdata;
        `ERS_ENC_SR_MISC3:   state_next.misc3   = i_wdata;
        default:             state_next = state_reg;
      endcase
    end
  end

  always_comb begin
    o_hit   = 1'b1;
    o_rdata = 64'h0000000000000000;
    case (i_rd_enc)
      `ERS_ENC_SR_CONTROL: o_rdata = state_reg.control;
      `ERS_ENC_SR_STATUS:  o_rdata = state_reg.status;
      `ERS_ENC_SR_PF_CTRL: o_rdata = state_reg.pf_ctrl;
      `ERS_ENC_SR_MISC1:   o_rdata = state_reg.misc1;
      `ERS_ENC_SR_MISC2:   o_rdata = state_reg.misc2;
      `ERS_ENC_SR_MISC3:   o_rdata = state_reg.misc3;
      default:             o_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= '{default: `ERS_RECORD_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// *** core/ers_regs.sv ***
// Function
// - Count register reads two in low bits
// - Count zero means no records reachable
// - Select register names the accessed record
// - Select zero routes to shared-unit record
// - Select one routes to core record
// - Zero records: select reads zero, ignored
// - Level zero access is undefined
// - Hyp trap bit traps to level two first
// - Fine read-trap bit traps reads to two
// - Fine write-trap bit traps select writes
// - Monitor trap bit traps to level three
// - Level three accesses never trap
// - Selected-record registers reset to zero
// - Selected-record registers follow select bit
`timescale 1ns/1ps
`default_nettype none

`include "ers_defs.svh"

module ers_regs
  import ers_pkg::*;
#(
  parameter logic [15:0] NUM_RECORDS = `ERS_NUM_RECORDS
)
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  // System register access
  input  wire ers_req_t      i_req,
  input  wire ers_trap_cfg_t i_cfg,
  output ers_resp_t          o_resp,
  // Current record selection
  output logic               o_record_sel
);

  typedef struct packed {
    logic      sel;
    ers_resp_t resp;
  } ers_state_t;

  ers_state_t state_reg;
  ers_state_t state_next;

  logic         recs_present;
  logic         is_count;
  logic         is_select;
  logic         is_record;
  ers_outcome_t outcome;
  logic         allowed;
  logic [1:0]   rec_hit;
  logic [63:0]  rec_rdata [2];

  // Only the listed encodings count; the holes between them stay undefined.
  function automatic logic is_record_enc(input logic [15:0] enc);
    return (enc >= `ERS_ENC_SR_FEATURE && enc <= `ERS_ENC_SR_PF_CDN) ||
           (enc >= `ERS_ENC_SR_MISC0 && enc <= `ERS_ENC_SR_MISC3);
  endfunction

  assign recs_present = NUM_RECORDS != 16'h0000;
  assign is_count     = i_req.enc == `ERS_ENC_COUNT_ID;
  assign is_select    = i_req.enc == `ERS_ENC_SELECT;
  assign is_record    = is_record_enc(i_req.enc) && recs_present;

  // Access check, evaluated in the order the trap controls take priority.
  always_comb begin
    outcome = ERS_OK;
    if (!(is_count || is_select || is_record)) begin
      outcome = ERS_UNDEF;
    end else if (is_count && i_req.write) begin
      outcome = ERS_UNDEF;
    end else if (i_req.el == ERS_EL0) begin
      outcome = ERS_UNDEF;
    end else if (i_req.el == ERS_EL1) begin
      if (i_cfg.el2_enabled && i_cfg.hyp_error_reg_trap) begin
        outcome = ERS_TRAP_EL2;
      end else if (i_cfg.el2_enabled && i_cfg.fine_trap_enable &&
                   !i_req.write &&
                   ((is_count && i_cfg.fine_read_trap_count_id) ||
                    (is_select && i_cfg.fine_read_trap_select))) begin
        outcome = ERS_TRAP_EL2;
      end else if (i_cfg.el2_enabled && i_cfg.fine_trap_enable &&
                   i_req.write && is_select &&
                   i_cfg.fine_write_trap_select) begin
        outcome = ERS_TRAP_EL2;
      end else if (i_cfg.monitor_error_reg_trap) begin
        outcome = ERS_TRAP_EL3;
      end
    end else if (i_req.el == ERS_EL2) begin
      if (i_cfg.monitor_error_reg_trap) begin
        outcome = ERS_TRAP_EL3;
      end
    end else begin
      outcome = ERS_OK;
    end
  end

  assign allowed = i_req.valid && outcome == ERS_OK;

  // Both records are always present; the select bit only steers the port.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rec
      ers_record_bank u_bank (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_wr     (allowed && i_req.write && is_record &&
                   state_reg.sel == 1'(g)),
        .i_enc    (i_req.enc),
        .i_wdata  (i_req.wdata),
        .i_rd_enc (i_req.enc),
        .o_hit    (rec_hit[g]),
        .o_rdata  (rec_rdata[g])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.resp.valid          = i_req.valid;
    state_next.resp.outcome        = outcome;
    state_next.resp.syndrome_class = 6'h00;
    state_next.resp.rdata          = 64'h0000000000000000;
    if (i_req.valid && (outcome == ERS_TRAP_EL2 ||
                        outcome == ERS_TRAP_EL3)) begin
      state_next.resp.syndrome_class = `ERS_TRAP_CLASS;
    end
    if (allowed && !i_req.write) begin
      if (is_count) begin
        state_next.resp.rdata = {48'h000000000000, NUM_RECORDS};
      end else if (is_select) begin
        // Without records the select register reads as zero.
        state_next.resp.rdata = {63'h0, state_reg.sel & recs_present};
      end else if (state_reg.sel) begin
        state_next.resp.rdata = rec_hit[1] ? rec_rdata[1] : 64'h0;
      end else begin
        state_next.resp.rdata = rec_hit[0] ? rec_rdata[0] : 64'h0;
      end
    end
    // Only bit 0 of the source is kept; the rest is discarded.
    if (allowed && i_req.write && is_select && recs_present) begin
      state_next.sel = i_req.wdata[`ERS_SEL_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_resp       = state_reg.resp;
  assign o_record_sel = state_reg.sel;

endmodule

`default_nettype wire

// *** verif/ers_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ers_defs.svh"
module ers_chk
  import ers_pkg::*;
#(
  parameter logic [15:0] NUM_RECORDS = `ERS_NUM_RECORDS
)
(
  // Watched ports
  input wire logic          i_clk,
  input wire logic          i_resetn,
  input wire ers_req_t      i_req,
  input wire ers_trap_cfg_t i_cfg,
  input wire ers_resp_t     o_resp,
  input wire logic          o_record_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire logic is_sel = i_req.enc == `ERS_ENC_SELECT;
  wire logic is_cnt = i_req.enc == `ERS_ENC_COUNT_ID;
  // Writes to the count encoding are refused before any trap check.
  wire logic ok_enc = is_sel || (is_cnt && !i_req.write);
  wire logic rq = i_req.valid && ok_enc;
  sequence s_sel_wr;
    rq && i_req.write && is_sel && i_req.el == ERS_EL3 &&
      NUM_RECORDS != 16'h0000;
  endsequence
  a_el0_undef:
    assert property (rq && i_req.el == ERS_EL0 |=>
      o_resp.outcome == ERS_UNDEF) else $error("level zero not undefined");
  a_hyp_first:
    assert property (rq && i_req.el == ERS_EL1 && i_cfg.el2_enabled &&
      i_cfg.hyp_error_reg_trap |=> o_resp.outcome == ERS_TRAP_EL2)
      else $error("hyp trap missed");
  a_class_code:
    assert property (o_resp.valid && o_resp.outcome[1] |->
      o_resp.syndrome_class == `ERS_TRAP_CLASS) else $error("bad class");
  a_monitor_el2:
    assert property (rq && i_req.el == ERS_EL2 &&
      i_cfg.monitor_error_reg_trap |=> o_resp.outcome == ERS_TRAP_EL3)
      else $error("monitor trap missed");
  a_el3_free:
    assert property (rq && i_req.el == ERS_EL3 |=> o_resp.valid &&
      o_resp.outcome == ERS_OK) else $error("level three refused");
  a_sel_load:
    assert property (s_sel_wr |=> o_record_sel == $past(i_req.wdata[0]))
      else $error("select not loaded");
  a_sel_hold:
    assert property (!(i_req.valid && i_req.write && is_sel) |=>
      $stable(o_record_sel)) else $error("select moved");
  a_count_value:
    assert property (rq && !i_req.write && is_cnt && i_req.el == ERS_EL3
      |=> o_resp.rdata == {48'h0, NUM_RECORDS}) else $error("bad count");
endmodule
`default_nettype wire

// *** verif/ers_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ers_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t value %0h", $time, a); end end
bind ers_regs ers_chk #(.NUM_RECORDS(NUM_RECORDS)) u_chk (.i_clk,
  .i_resetn, .i_req, .i_cfg, .o_resp, .o_record_sel);
module ers_regs_test
  import ers_pkg::*;
;
  logic          i_clk = 1'h0;
  logic          i_resetn = 1'h0;
  ers_req_t      i_req = '0;
  ers_trap_cfg_t i_cfg = '0;
  ers_resp_t     o_resp;
  logic          o_record_sel;
  ers_resp_t     r;
  ers_resp_t     o_resp_none;
  logic          o_record_sel_none;
  ers_resp_t     r0;
  int            fails = 0;
  int            n_tests = 0;
  always #12.5 i_clk = ~i_clk;
  ers_regs u_dut (.i_clk, .i_resetn, .i_req, .i_cfg, .o_resp, .o_record_sel);
  // A build without records sees the same requests.
  ers_regs #(.NUM_RECORDS(16'h0000)) u_dut_none (.i_clk, .i_resetn, .i_req,
    .i_cfg, .o_resp(o_resp_none), .o_record_sel(o_record_sel_none));
  // The answer is registered, so it is read one edge after the request.
  task automatic acc(input logic w, input logic [15:0] e, input ers_el_t el,
                     input logic [63:0] d);
    @(posedge i_clk) #1;
    i_req = '{1'h1, w, e, el, d};
    @(posedge i_clk) #1;
    r = o_resp;
    r0 = o_resp_none;
    i_req.valid = 1'h0;
    `CHK(r.valid, 1'h1)
  endtask
  task automatic trap(input logic [6:0] c, input ers_el_t el, input logic w,
                      input logic [15:0] e, input ers_outcome_t x);
    i_cfg = c;
    acc(w, e, el, 64'h0);
    `CHK(r.outcome, x)
    `CHK(r.syndrome_class, x[1] ? `ERS_TRAP_CLASS : 6'h00)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset();
    `CHK(o_record_sel, 1'h0)
    acc(1'h0, `ERS_ENC_SR_STATUS, ERS_EL3, 64'h0);
    `CHK(r.rdata, 64'h0)
  endtask
  task automatic t_count();
    acc(1'h0, `ERS_ENC_COUNT_ID, ERS_EL1, 64'h0);
    `CHK(r.rdata, {48'h0, `ERS_NUM_RECORDS})
    trap(7'h00, ERS_EL3, 1'h1, `ERS_ENC_COUNT_ID, ERS_UNDEF);
    trap(7'h00, ERS_EL0, 1'h0, `ERS_ENC_SELECT, ERS_UNDEF);
    trap(7'h00, ERS_EL3, 1'h0, 16'hC2A7, ERS_UNDEF);
  endtask
  task automatic t_select();
    acc(1'h1, `ERS_ENC_SELECT, ERS_EL3, 64'hFFFF_FFFF_FFFF_FFFF);
    `CHK(o_record_sel, 1'h1)
    acc(1'h0, `ERS_ENC_SELECT, ERS_EL2, 64'h0);
    `CHK(r.rdata, 64'h1)
    acc(1'h1, `ERS_ENC_SR_CONTROL, ERS_EL3, 64'hA5);
    acc(1'h1, `ERS_ENC_SELECT, ERS_EL2, 64'h2);
    `CHK(o_record_sel, 1'h0)
    acc(1'h0, `ERS_ENC_SR_CONTROL, ERS_EL3, 64'h0);
    `CHK(r.rdata, 64'h0)
    acc(1'h1, `ERS_ENC_SELECT, ERS_EL1, 64'h1);
    acc(1'h0, `ERS_ENC_SR_CONTROL, ERS_EL3, 64'h0);
    `CHK(r.rdata, 64'hA5)
  endtask
  task automatic t_traps();
    trap(7'h70, ERS_EL1, 1'h0, `ERS_ENC_SELECT, ERS_TRAP_EL2);
    trap(7'h4A, ERS_EL1, 1'h0, `ERS_ENC_SELECT, ERS_TRAP_EL2);
    trap(7'h4C, ERS_EL1, 1'h0, `ERS_ENC_COUNT_ID, ERS_TRAP_EL2);
    trap(7'h49, ERS_EL1, 1'h1, `ERS_ENC_SELECT, ERS_TRAP_EL2);
    `CHK(o_record_sel, 1'h1)
    trap(7'h10, ERS_EL1, 1'h0, `ERS_ENC_COUNT_ID, ERS_TRAP_EL3);
    trap(7'h10, ERS_EL2, 1'h1, `ERS_ENC_SELECT, ERS_TRAP_EL3);
    trap(7'h7F, ERS_EL3, 1'h1, `ERS_ENC_SELECT, ERS_OK);
    `CHK(o_record_sel, 1'h0)
  endtask
  task automatic t_none();
    acc(1'h1, `ERS_ENC_SELECT, ERS_EL3, 64'h1);
    `CHK(o_record_sel_none, 1'h0)
    acc(1'h0, `ERS_ENC_SELECT, ERS_EL3, 64'h0);
    `CHK(r0.rdata, 64'h0)
    acc(1'h0, `ERS_ENC_COUNT_ID, ERS_EL3, 64'h0);
    `CHK(r0.rdata, 64'h0)
    acc(1'h0, `ERS_ENC_SR_CONTROL, ERS_EL3, 64'h0);
    `CHK(r0.outcome, ERS_UNDEF)
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_resetn = 1'h1;
    t_reset();
    t_count();
    t_select();
    t_traps();
    t_none();
    tally_and_finish();
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
